// [sc_ctrl.sv]
// Sound serial controller: Wishbone registers, clock generation, serial
// engine. Assumes serial pins synchronous to i_mclk, pad logic outside.
// Function
// RULE1: Soft reset clears all registers, reads zero
// RULE2: Zero command bits do nothing
// RULE3: Transmit enable unless disable; flag when started
// RULE4: Transmit disable; flag clears when really stopped
// RULE5: Clock enable unless disable; disable stops clocks
// RULE6: Receive enable unless disable; disable stops receiver
// RULE7: Software configures mode only while stopped
// RULE8: Slot width bit picks 32 or 24
// RULE9: Bit clock direct or divided from master clock
// RULE10: Software avoids master clock equal bit clock
// RULE11: Master clock is 16*(ratio+1) sample rate
// RULE12: Underrun sends zero or previous sample
// RULE13: Transmit DMA shared or per channel
// RULE14: Receive DMA shared or per channel
// RULE15: Mono copies left sample onto right
// RULE16: Loop-back routes data out into in
// RULE17: Word length field encodes eight lengths
// RULE18: Packed stereo halves: left low, right high
// RULE19: Slave takes bit clock and select inputs
// RULE20: Master drives bit clock, select, master clock
// RULE21: Version and parameter fixed read-only words
// RULE22: Receive ready set on word, cleared on read
// RULE23: Transmit ready while holding empty, cleared on write
// RULE24: Clear and set registers drive error flags
// RULE25: Channel bit i marks error channel i
// RULE26: Status bits at fixed positions
// RULE27: Interrupt while enabled status bit set
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
module sc_ctrl import sc_pkg::*; #(
	parameter int GCLK_DIV = GCLK_DIV_DEF,
	parameter logic [31:0] VERSION = VERSION_DEF,
	parameter logic [31:0] PARAMS = PARAM_DEF
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire sc_wb_req_t i_wb,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_bclk,
	output logic o_bclk,
	output logic o_bclk_oe,
	input wire logic i_ws,
	output logic o_ws,
	output logic o_ws_oe,
	output logic o_mck,
	output logic o_mck_oe,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic [1:0] o_tx_dma_req,
	output logic [1:0] o_rx_dma_req,
	output logic o_irq
);
	// ==========================================================
	// Declarations
	sc_clk_t c_q, c_d;
	sc_core_t k_q, k_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d, rmux, wdat, stat_w, lowm, smp, hi, rxw;
	logic [9:0] transmit_holding, acc_n;
	logic [5:0] wlen, slot;
	logic req, wr, rd, srst, gtick, run_m, m_tog, pk, need, ch, pc;
	logic wr_ctrl, wr_mode, wr_sclr, wr_sset, wr_ien, wr_idis, wr_thr;
	logic rd_rhr, b_rise, b_fall, ws_line, slot_start, frame_start;
	logic sdi_line, tx_rdy, rx_commit;

	generate
		if (GCLK_DIV < 2 || GCLK_DIV > 256) begin : g_chk
			$error("GCLK_DIV must be 2 to 256");
		end
	endgenerate

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// ==========================================================
	// Bus decode
	assign req = i_wb.cyc & i_wb.stb;
	assign wr = req & i_wb.we & ack_q;
	assign rd = req & ~i_wb.we & ack_q;
	assign wdat = i_wb.dat & {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}},
		{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
	assign wr_ctrl = wr && i_wb.adr[7:2] == OFS_CTRL[7:2];
	assign wr_mode = wr && i_wb.adr[7:2] == OFS_MODE[7:2];
	assign wr_sclr = wr && i_wb.adr[7:2] == OFS_SCLR[7:2];
	assign wr_sset = wr && i_wb.adr[7:2] == OFS_SSET[7:2];
	assign wr_ien = wr && i_wb.adr[7:2] == OFS_IEN[7:2];
	assign wr_idis = wr && i_wb.adr[7:2] == OFS_IDIS[7:2];
	assign wr_thr = wr && i_wb.adr[7:2] == OFS_THR[7:2];
	assign rd_rhr = rd && i_wb.adr[7:2] == OFS_RHR[7:2];
	assign srst = wr_ctrl & wdat[CMD_SOFT_RESET_CMD]; // [RULE1]

	// Status word layout
	assign tx_rdy = k_q.tx_on & ~k_q.thr_full; // [RULE23]
	assign stat_w = {10'h000, k_q.ur_ch, 10'h000, k_q.or_ch, 1'b0,
		k_q.tx_ur, tx_rdy, k_q.tx_on, 1'b0, k_q.rx_or, k_q.rx_rdy,
		k_q.rx_on}; // [RULE26]

	// Read multiplexer, write-only and unmapped read zero
	always_comb begin : read_mux
		unique case (i_wb.adr[7:2])
			OFS_MODE[7:2]: rmux = k_q.mode;
			OFS_STAT[7:2]: rmux = stat_w;
			OFS_IMSK[7:2]: rmux = k_q.irq_mask;
			OFS_RHR[7:2]: rmux = k_q.receive_holding;
			OFS_VER[7:2]: rmux = VERSION; // [RULE21]
			OFS_PAR[7:2]: rmux = PARAMS; // [RULE21]
			default: rmux = 32'h0000_0000; // [RULE1]
		endcase
	end

	// Bus answer one cycle after the request
	always_comb begin : bus_next
		ack_d = req & ~ack_q;
		rdat_d = (ack_d & ~i_wb.we) ? rmux : 32'h0000_0000;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin : bus_reg
		if (!i_rst_b) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// ==========================================================
	// Word and slot length decode
	always_comb begin : len_dec
		unique case (k_q.mode.wlen) // [RULE17]
			WL_32: begin wlen = 6'd32; slot = 6'd32; end
			WL_24: begin wlen = 6'd24; slot = 6'd32; end
			WL_20: begin wlen = 6'd20; slot = 6'd32; end
			WL_18: begin wlen = 6'd18; slot = 6'd32; end
			WL_16, WL_16P: begin wlen = 6'd16; slot = 6'd16; end
			WL_8, WL_8P: begin wlen = 6'd8; slot = 6'd8; end
		endcase
		if (k_q.mode.slot24 && (k_q.mode.wlen == WL_24 ||
			k_q.mode.wlen == WL_20 || k_q.mode.wlen == WL_18)) begin
			slot = 6'd24; // [RULE8]
		end
	end
	assign pk = k_q.mode.wlen == WL_16P || k_q.mode.wlen == WL_8P;
	assign lowm = 32'hffff_ffff >> (6'd32 - wlen);

	// ==========================================================
	// Clock generation, master mode
	assign gtick = c_q.div == 8'(GCLK_DIV - 1);
	assign run_m = k_q.mode.master & k_q.clk_on; // [RULE5]
	assign transmit_holding = {7'(k_q.mode.ratio) + 7'h01, 3'h0}; // [RULE11]
	assign acc_n = c_q.acc + {4'h0, slot};

	always_comb begin : clk_next
		c_d = c_q;
		m_tog = 1'b0;
		c_d.div = gtick ? 8'h00 : c_q.div + 8'h01;
		if (run_m && gtick) begin
			c_d.mck = k_q.mode.mck_mode ? ~c_q.mck : 1'b0; // [RULE20]
			if (!k_q.mode.mck_mode) begin
				m_tog = 1'b1; // [RULE9]
			end else if (acc_n >= transmit_holding) begin
				m_tog = 1'b1; // [RULE9] [RULE11]
				c_d.acc = acc_n - transmit_holding;
			end else begin
				c_d.acc = acc_n;
			end
		end
		if (m_tog) begin
			c_d.bclk = ~c_q.bclk;
			if (c_q.bclk) begin
				if (c_q.bitcnt == slot - 6'd1) begin
					c_d.bitcnt = 6'd0;
					c_d.ws = ~c_q.ws;
				end else begin
					c_d.bitcnt = c_q.bitcnt + 6'd1;
				end
			end
		end
		if (!run_m || srst || (wr_ctrl && wdat[CMD_CLKGEN_DISABLE_CMD])) begin // [RULE5]
			c_d.acc = 10'h000;
			c_d.bclk = 1'b0;
			c_d.ws = 1'b0;
			c_d.bitcnt = 6'd0;
			c_d.mck = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin : clk_reg
		if (!i_rst_b) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// ==========================================================
	// Serial events from either clock source
	assign b_rise = k_q.mode.master ? (m_tog & ~c_q.bclk) :
		(i_bclk & ~k_q.bclk_in); // [RULE19]
	assign b_fall = k_q.mode.master ? (m_tog & c_q.bclk) :
		(~i_bclk & k_q.bclk_in); // [RULE19]
	assign ws_line = k_q.mode.master ? c_q.ws : i_ws; // [RULE19]
	assign slot_start = b_fall & (ws_line != k_q.ws_seen);
	assign frame_start = slot_start & ~ws_line;
	assign ch = ws_line;
	assign pc = k_q.ws_seen;
	assign sdi_line = k_q.mode.loop ? k_q.sdo : i_sdi; // [RULE16]
	assign need = (pk | k_q.mode.tx_mono) ? ~ch : 1'b1;

	// Core registers and serial engine
	always_comb begin : core_next
		k_d = k_q;
		smp = 32'h0000_0000;
		hi = 32'h0000_0000;
		rxw = 32'h0000_0000;
		rx_commit = 1'b0;
		k_d.bclk_in = i_bclk;
		if (b_fall) begin
			k_d.ws_seen = ws_line;
		end
		// Commands, a zero bit leaves state alone
		if (wr_ctrl) begin
			if (wdat[CMD_TX_ENABLE_CMD] && !wdat[CMD_TX_DISABLE_CMD]) k_d.tx_req = 1'b1; // [RULE3]
			if (wdat[CMD_TX_DISABLE_CMD]) k_d.tx_req = 1'b0; // [RULE4] [RULE2]
			if (wdat[CMD_RX_ENABLE_CMD] && !wdat[CMD_RX_DISABLE_CMD]) k_d.rx_req = 1'b1; // [RULE6]
			if (wdat[CMD_RX_DISABLE_CMD]) k_d.rx_req = 1'b0; // [RULE6] [RULE2]
			if (wdat[CMD_CLKGEN_ENABLE_CMD] && !wdat[CMD_CLKGEN_DISABLE_CMD]) k_d.clk_on = 1'b1; // [RULE5]
			if (wdat[CMD_CLKGEN_DISABLE_CMD]) k_d.clk_on = 1'b0; // [RULE5]
		end
		if (wr_mode) begin
			k_d.mode = sc_mode_t'((k_q.mode & ~(MODE_WMASK &
				{{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}},
				{8{i_wb.sel[0]}}})) | (wdat & MODE_WMASK));
		end
		if (wr_ien) k_d.irq_mask = k_q.irq_mask | (wdat & IMSK_MASK);
		if (wr_idis) k_d.irq_mask = k_d.irq_mask & ~wdat;
		// Software clear, then set, then hardware events
		if (wr_sclr) begin
			if (wdat[ST_TX_UNDERRUN_FLAG]) begin
				k_d.tx_ur = 1'b0; // [RULE24]
				k_d.ur_ch = 2'b00;
			end
			if (wdat[ST_RX_OVERRUN_FLAG]) begin
				k_d.rx_or = 1'b0; // [RULE24]
				k_d.or_ch = 2'b00;
			end
			k_d.ur_ch = k_d.ur_ch & ~wdat[ST_URCH+:2];
			k_d.or_ch = k_d.or_ch & ~wdat[ST_ORCH+:2];
		end
		if (wr_sset) begin
			k_d.tx_ur = k_d.tx_ur | wdat[ST_TX_UNDERRUN_FLAG]; // [RULE24]
			k_d.rx_or = k_d.rx_or | wdat[ST_RX_OVERRUN_FLAG];
			k_d.ur_ch = k_d.ur_ch | wdat[ST_URCH+:2];
			k_d.or_ch = k_d.or_ch | wdat[ST_ORCH+:2];
		end
		if (rd_rhr) k_d.rx_rdy = 1'b0; // [RULE22]
		// Slot boundary: start or stop only at frame start
		if (slot_start) begin
			k_d.tx_on = frame_start ? k_q.tx_req : k_q.tx_on; // [RULE3] [RULE4]
			k_d.rx_on = frame_start ? k_q.rx_req : k_q.rx_on; // [RULE6]
			if (k_d.tx_on) begin
				if (!need) begin
					smp = pk ? k_q.pk_hi : k_q.prev[0]; // [RULE15] [RULE18]
				end else if (k_q.thr_full) begin
					smp = k_q.transmit_holding & lowm; // [RULE18]
					hi = (k_q.transmit_holding >> wlen) & lowm;
					k_d.thr_full = 1'b0;
				end else begin
					smp = k_q.mode.repeat_ur ? k_q.prev[ch] : 32'h0; // [RULE12]
					hi = k_q.mode.repeat_ur ? k_q.prev[1] : 32'h0;
					k_d.tx_ur = 1'b1;
					k_d.ur_ch[ch] = 1'b1; // [RULE25]
				end
				if (need) k_d.pk_hi = hi;
				k_d.prev[ch] = smp;
			end
			k_d.tx_sh = smp << (6'd32 - wlen);
			k_d.sdo = k_d.tx_sh[31];
			// Deliver the finished slot of the previous channel
			if (k_q.rx_on && k_q.rx_have) begin
				rxw = (pc && k_q.mode.rx_mono) ? k_q.rx_lo : k_q.rx_sh; // [RULE15]
				if (!pc) k_d.rx_lo = k_q.rx_sh;
				if (pk) rxw = (rxw << wlen) | k_q.rx_lo; // [RULE18]
				if (!pk || pc) begin
					rx_commit = 1'b1;
					if (k_d.rx_rdy) begin
						k_d.rx_or = 1'b1;
						k_d.or_ch[pc] = 1'b1; // [RULE25]
					end
					k_d.receive_holding = rxw;
					k_d.rx_rdy = 1'b1; // [RULE22]
					k_d.rx_ch = pc;
				end
			end
			k_d.rx_have = k_d.rx_on;
			k_d.rx_cnt = 6'd0;
			k_d.rx_sh = 32'h0000_0000;
		end else if (b_fall && k_q.tx_on) begin
			k_d.tx_sh = {k_q.tx_sh[30:0], 1'b0};
			k_d.sdo = k_q.tx_sh[30];
		end
		// Extra bits beyond the word length are dropped
		if (b_rise && k_q.rx_on && k_q.rx_cnt < wlen && !slot_start) begin
			k_d.rx_sh = {k_q.rx_sh[30:0], sdi_line};
			k_d.rx_cnt = k_q.rx_cnt + 6'd1;
		end
		// New holding data wins over the slot that drained it
		if (wr_thr) begin
			k_d.transmit_holding = i_wb.dat;
			k_d.thr_full = 1'b1; // [RULE23]
		end
		if (srst) k_d = '0; // [RULE1]
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin : core_reg
		if (!i_rst_b) begin
			k_q <= '0;
		end else begin
			k_q <= k_d;
		end
	end

	// ==========================================================
	// Outputs
	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_bclk = c_q.bclk;
	assign o_bclk_oe = k_q.mode.master; // [RULE19] [RULE20]
	assign o_ws = c_q.ws;
	assign o_ws_oe = k_q.mode.master; // [RULE20]
	assign o_mck = c_q.mck;
	assign o_mck_oe = k_q.mode.master & k_q.mode.mck_mode; // [RULE20]
	assign o_sdo = k_q.sdo;
	assign o_tx_dma_req = k_q.mode.tx_dma ?
		({k_q.ws_seen, ~k_q.ws_seen} ^ 2'b11) & {2{tx_rdy}} :
		{1'b0, tx_rdy}; // [RULE13]
	assign o_rx_dma_req = k_q.mode.rx_dma ?
		{k_q.rx_ch, ~k_q.rx_ch} & {2{k_q.rx_rdy}} :
		{1'b0, k_q.rx_rdy}; // [RULE14]
	assign o_irq = |(stat_w & k_q.irq_mask); // [RULE27]

	// ==========================================================
	// Assertions
	a_soft_reset_cmd_all: assert property (srst |=> k_q.mode == '0 && // [RULE1]
		!k_q.tx_on && !k_q.rx_on && k_q.irq_mask == '0)
		else $error("soft reset left state");
	a_zero_cmd: assert property ( // [RULE2]
		(wr_ctrl && (wdat & CMD_MASK) == '0) |=> $stable(k_q.tx_req) &&
		$stable(k_q.rx_req) && $stable(k_q.clk_on))
		else $error("zero command changed state");
	a_tx_start: assert property ($rose(k_q.tx_on) |-> // [RULE3]
		$past(frame_start) && $past(k_q.tx_req))
		else $error("transmitter started off frame");
	a_tx_both: assert property ( // [RULE3]
		(wr_ctrl && wdat[CMD_TX_ENABLE_CMD] && wdat[CMD_TX_DISABLE_CMD]) |=> !k_q.tx_req)
		else $error("enable beat disable");
	a_tx_stop: assert property ($fell(k_q.tx_on) |-> // [RULE4]
		$past(frame_start) || $past(srst))
		else $error("transmitter stopped early");
	a_clk_dis: assert property ( // [RULE5]
		(wr_ctrl && wdat[CMD_CLKGEN_DISABLE_CMD]) |=> !k_q.clk_on && !c_q.bclk)
		else $error("clock not stopped");
	a_rx_en: assert property ((wr_ctrl && wdat[CMD_RX_ENABLE_CMD] && // [RULE6]
		!wdat[CMD_RX_DISABLE_CMD] && !srst) |=> k_q.rx_req)
		else $error("receiver not requested");
	a_mck_direct: assert property ((run_m && gtick && // [RULE9]
		!k_q.mode.mck_mode && !srst && !wr_ctrl) |=> c_q.bclk != $past(c_q.bclk))
		else $error("bit clock not direct");
	a_thr_full: assert property ((wr_thr && !srst) |=> !tx_rdy) // [RULE23]
		else $error("transmit ready not cleared");
	a_rhr_read: assert property ( // [RULE22]
		(rd_rhr && !rx_commit && !srst) |=> !k_q.rx_rdy)
		else $error("receive ready not cleared");
	a_pin_dir: assert property ( // [RULE19]
		!k_q.mode.master |-> !o_bclk_oe && !o_ws_oe && !o_mck_oe)
		else $error("slave drives clock pins");
	c_tx_start: cover property ($rose(k_q.tx_on));
	c_rx_word: cover property (rx_commit ##1 k_q.rx_rdy);
	c_underrun: cover property ($rose(k_q.tx_ur) && !$past(wr_sset));
	c_packed: cover property (pk && rx_commit);
endmodule // sc_ctrl

// [sc_pkg.sv]
// Package for the sound serial controller: register map, fields, types.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package sc_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_SCLR = 8'h0c;
	localparam logic [7:0] OFS_SSET = 8'h10;
	localparam logic [7:0] OFS_IEN = 8'h14;
	localparam logic [7:0] OFS_IDIS = 8'h18;
	localparam logic [7:0] OFS_IMSK = 8'h1c;
	localparam logic [7:0] OFS_RHR = 8'h20;
	localparam logic [7:0] OFS_THR = 8'h24;
	localparam logic [7:0] OFS_VER = 8'h28;
	localparam logic [7:0] OFS_PAR = 8'h2c;
	// ==========================================================
	// Command bit positions
	localparam int CMD_RX_ENABLE_CMD = 0;
	localparam int CMD_RX_DISABLE_CMD = 1;
	localparam int CMD_CLKGEN_ENABLE_CMD = 2;
	localparam int CMD_CLKGEN_DISABLE_CMD = 3;
	localparam int CMD_TX_ENABLE_CMD = 4;
	localparam int CMD_TX_DISABLE_CMD = 5;
	localparam int CMD_SOFT_RESET_CMD = 7;
	// ==========================================================
	// Status bit positions and masks
	localparam int ST_RX_OVERRUN_FLAG = 2;
	localparam int ST_TX_UNDERRUN_FLAG = 6;
	localparam int ST_ORCH = 8;
	localparam int ST_URCH = 20;
	localparam logic [31:0] MODE_WMASK = 32'hff00_771d;
	localparam logic [31:0] IMSK_MASK = 32'h0000_0066;
	localparam logic [31:0] CMD_MASK = 32'h0000_00bf;
	// Identity words, values arbitrary
	localparam logic [31:0] VERSION_DEF = 32'h0000_0101;
	localparam logic [31:0] PARAM_DEF = 32'h0000_0001;
	// Generic clock tick divider default
	localparam int GCLK_DIV_DEF = 4;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		WL_32, WL_24, WL_20, WL_18, WL_16, WL_16P, WL_8, WL_8P
	} sc_wlen_t;
	typedef struct packed {
		logic slot24;
		logic mck_mode;
		logic [5:0] ratio;
		logic [7:0] rsv_a;
		logic rsv_b;
		logic repeat_ur;
		logic tx_dma;
		logic tx_mono;
		logic rsv_c;
		logic loop;
		logic rx_dma;
		logic rx_mono;
		logic [2:0] rsv_d;
		sc_wlen_t wlen;
		logic rsv_e;
		logic master;
	} sc_mode_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sc_wb_req_t;
	typedef struct packed {
		logic [7:0] div;
		logic [9:0] acc;
		logic bclk;
		logic ws;
		logic [5:0] bitcnt;
		logic mck;
	} sc_clk_t;
	typedef struct packed {
		sc_mode_t mode;
		logic [31:0] irq_mask;
		logic [31:0] transmit_holding;
		logic [31:0] receive_holding;
		logic [1:0][31:0] prev;
		logic [31:0] pk_hi;
		logic [31:0] rx_lo;
		logic [31:0] tx_sh;
		logic [31:0] rx_sh;
		logic [5:0] rx_cnt;
		logic tx_ur;
		logic rx_or;
		logic [1:0] ur_ch;
		logic [1:0] or_ch;
		logic tx_req;
		logic rx_req;
		logic clk_on;
		logic tx_on;
		logic rx_on;
		logic thr_full;
		logic rx_rdy;
		logic rx_ch;
		logic rx_have;
		logic ws_seen;
		logic bclk_in;
		logic sdo;
	} sc_core_t;
endpackage

// [sc_codec_model.sv]
// Far-side model: external bit clock and word select master for slave
// mode, plus a serial data source. Assumes the design's i_mclk.
`timescale 1ns/100ps
module sc_codec_model (
	input wire logic i_mclk,
	input wire logic i_en,
	output logic o_bclk,
	output logic o_ws,
	output logic o_sdi
);
	logic div_q;
	logic [4:0] bitn_q;
	// ==========================================================
	// Start-up levels
	initial begin
		o_bclk = 1'b0;
		o_ws = 1'b0;
		o_sdi = 1'b0;
		div_q = 1'b0;
		bitn_q = 5'h00;
	end
	// ==========================================================
	// Clocks stand still while idle, data line wanders then
	always @(posedge i_mclk) begin
		div_q <= ~div_q;
		if (!i_en) begin
			o_sdi <= ~o_sdi; // Released line, no stale level
		end else if (div_q) begin
			o_bclk <= ~o_bclk;
			if (o_bclk) begin
				bitn_q <= bitn_q + 5'h01;
				o_sdi <= bitn_q[0] ^ bitn_q[3];
				if (bitn_q == 5'h1f) begin
					o_ws <= ~o_ws;
				end
			end
		end
	end
endmodule // sc_codec_model

// [sc_ctrl_tb_top.sv]
// Testbench for the sound serial controller: Wishbone register tasks,
// a codec model in slave mode and loop-back in master mode.
`timescale 1ns/100ps
module sc_ctrl_tb_top import sc_pkg::*;;
	logic i_mclk = 1'b0;
	logic i_rst_b, ack, bclk, bclk_oe, ws, ws_oe, mck, mck_oe;
	logic sdo, irq, m_en, m_bclk, m_ws, m_sdi;
	logic [1:0] txd, rxd;
	logic [31:0] wdat, q, x;
	logic [63:0] e;
	logic [63:0] expq[$];
	sc_wb_req_t wb;
	int fails, n_checks, a, c, mc, wc;
	// ==========================================================
	// Design, far side and shared pins
	sc_ctrl #(.GCLK_DIV(2)) sc_ctrl_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_wb(wb), .o_wb_dat(wdat), .o_wb_ack(ack),
		.i_bclk(bclk_oe ? bclk : m_bclk), .o_bclk(bclk), .o_bclk_oe(bclk_oe),
		.i_ws(ws_oe ? ws : m_ws), .o_ws(ws), .o_ws_oe(ws_oe), .o_mck(mck),
		.o_mck_oe(mck_oe), .i_sdi(m_sdi), .o_sdo(sdo), .o_tx_dma_req(txd),
		.o_rx_dma_req(rxd), .o_irq(irq));
	sc_codec_model sc_codec_model_i (.i_mclk(i_mclk), .i_en(m_en),
		.o_bclk(m_bclk), .o_ws(m_ws), .o_sdi(m_sdi));
	always #10 i_mclk = ~i_mclk;
	// ==========================================================
	// Compare, verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// Classic Wishbone cycle, waits for ack under a bound
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: ad, sel: 4'hf, dat: d};
		k = 0;
		do begin
			@(posedge i_mclk);
			k++;
		end while (ack !== 1'b1 && k < 40);
		if (k >= 40) begin
			fails++;
			wrap_up;
		end
		q = wdat;
		wb <= '0;
		@(posedge i_mclk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] m, ex);
		expq.push_back({m, ex});
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic wait_st(input logic [31:0] m, v);
		int k;
		for (k = 0; k < 300; k++) begin
			rd(OFS_STAT, 32'h0, 32'h0);
			if ((q & m) === v) break;
		end
		chk(q & m, v);
	endtask
	// Count bit clock, master clock and word select changes
	task automatic tog(input int len, output int n, m, w);
		logic p, pm, pw;
		n = 0;
		m = 0;
		w = 0;
		p = bclk;
		pm = mck;
		pw = ws;
		repeat (len) begin
			@(posedge i_mclk);
			if (bclk !== p) n++;
			if (mck !== pm) m++;
			if (ws !== pw) w++;
			p = bclk;
			pm = mck;
			pw = ws;
		end
	endtask
	// ==========================================================
	// Read data watcher: oldest note against each read answer
	always @(posedge i_mclk) begin
		if (ack === 1'b1 && wb.we === 1'b0 && expq.size() > 0) begin
			e = expq.pop_front();
			if (e[63:32] != 32'h0) chk(wdat & e[63:32], e[31:0]);
		end
	end
	initial begin
		repeat (100000) @(posedge i_mclk);
		fails++;
		wrap_up;
	end
	// ==========================================================
	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		wb = '0;
		m_en = 1'b0;
		fails = 0;
		n_checks = 0;
		x = $urandom(32'he672);
		repeat (8) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		for (a = 0; a <= 8'h30; a += 4) begin
			rd(a[7:0], 32'hffff_ffff, a == OFS_VER ? VERSION_DEF :
				a == OFS_PAR ? PARAM_DEF : 32'h0);
		end
		for (a = 0; a < 8; a++) begin
			x = ($urandom & 32'hff00_7700) | {27'h0, a[2:0], 2'b00};
			wr(OFS_MODE, x);
			rd(OFS_MODE, 32'hffff_ffff, x);
		end
		wr(OFS_CTRL, 32'h80);
		rd(OFS_MODE, 32'hffff_ffff, 32'h0);
		rd(OFS_CTRL, 32'hffff_ffff, 32'h0);
		wr(OFS_IEN, 32'h66);
		rd(OFS_IMSK, 32'hffff_ffff, 32'h66);
		wr(OFS_IDIS, 32'h04);
		rd(OFS_IMSK, 32'hffff_ffff, 32'h62);
		wr(OFS_SSET, 32'h0030_0344);
		rd(OFS_STAT, 32'hffff_ffff, 32'h0030_0344);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IDIS, 32'h40);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_SCLR, 32'h0030_0344);
		rd(OFS_STAT, 32'hffff_ffff, 32'h0);
		// Slave mode, clocks from the codec model
		m_en <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		rd(OFS_STAT, 32'hffff_ffff, 32'h0);
		wr(OFS_CTRL, 32'h33);
		repeat (6) begin
			repeat (100) @(posedge i_mclk);
			rd(OFS_STAT, 32'h11, 32'h0);
		end
		chk({31'h0, bclk_oe}, 32'h0);
		wr(OFS_CTRL, 32'h11);
		wait_st(32'h31, 32'h31);
		chk({30'h0, txd}, 32'h1);
		wr(OFS_THR, x);
		rd(OFS_STAT, 32'h20, 32'h0);
		wr(OFS_CTRL, 32'h22);
		rd(OFS_STAT, 32'h10, 32'h10);
		wait_st(32'h11, 32'h0);
		chk({31'h0, sdo}, 32'h0);
		// Master mode, loop-back, mono, repeat on underrun
		m_en <= 1'b0;
		wr(OFS_CTRL, 32'h80);
		wr(OFS_MODE, 32'h0000_5401);
		wr(OFS_CTRL, 32'h04);
		chk({31'h0, bclk_oe}, 32'h1);
		chk({31'h0, ws_oe}, 32'h1);
		tog(40, c, mc, wc);
		chk({31'h0, c > 0}, 32'h1);
		x = $urandom;
		wr(OFS_THR, x);
		wr(OFS_CTRL, 32'h11);
		repeat (4) begin
			wait_st(32'h2, 32'h2);
			rd(OFS_RHR, 32'h0, 32'h0);
		end
		wait_st(32'h2, 32'h2);
		chk({30'h0, rxd}, 32'h1);
		rd(OFS_RHR, 32'hffff_ffff, x);
		rd(OFS_STAT, 32'h2, 32'h0);
		// Word select toggles once per 32-bit slot, no master clock
		tog(256, c, mc, wc);
		chk(wc * 64, c);
		chk(mc, 32'h0);
		// Clock enable against disable, master clock output
		wr(OFS_CTRL, 32'h80);
		wr(OFS_MODE, 32'h4f00_0001);
		wr(OFS_CTRL, 32'h0c);
		tog(40, c, mc, wc);
		chk(c, 32'h0);
		chk(mc, 32'h0);
		wr(OFS_CTRL, 32'h04);
		chk({31'h0, mck_oe}, 32'h1);
		// Master clock 256 fs against bit clock 64 fs: four to one
		tog(40, c, mc, wc);
		chk({31'h0, c > 0}, 32'h1);
		chk(mc, 4 * c);
		wrap_up;
	end
endmodule // sc_ctrl_tb_top
